/* File: rtl/csr_device.sv */
// Converter end: conversion start control, sampling timebase and result shifter
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: Chip-select rising edge starts new conversion
// R2: Thirty-second falling clock edge auto-starts conversion
// R3: Host applies at most 31 clocks
// R4: Sampling clock is 256 times notch
// R5: Any serial clock pace is accepted
// R6: Host spaces four chip-select edges evenly; this host drives a single select and starts each frame on request
// R7: Four interleaved converters quadruple result rate; not modelled, each converter here has its own link and host
// R8: External notch clock times sampling
// R9: Internal oscillator is ten times sampling
// R10: Shared clock and data, separate selects
// R11: Full readout is 32 bits
// R12: Data output released while chip select high
module csr_device #(
   parameter int unsigned CONV_TICKS = csr_pkg::CONV_FS_TICKS
) (
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic EXT_CLK_SEL_IN,
   input wire logic [csr_pkg::WORD_BITS-1:0] RESULT_IN,
   output logic CONV_START_OUT,
   output logic CONV_DONE_OUT,
   output logic FS_TICK_OUT,
   csr_link_if.dev LINK
);
   import csr_pkg::*;
   initial begin
      if (CONV_TICKS < 2) $error("CONV_TICKS too small");
   end
   typedef enum logic [0:0] {ST_CONV = 1'b0, ST_READY = 1'b1} csr_state_t;

   // Two-stage synchronisers for the pins
   logic [1:0] cs_sync;
   logic [1:0] sck_sync;
   logic [1:0] f0_sync;
   logic cs_q;
   logic sck_q;
   logic f0_q;
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         cs_sync <= 2'h3;
         sck_sync <= 2'h0;
         f0_sync <= 2'h0;
         cs_q <= 1'b1;
         sck_q <= 1'b0;
         f0_q <= 1'b0;
      end else begin
         cs_sync <= {cs_sync[0], LINK.cs_n};
         sck_sync <= {sck_sync[0], LINK.sck};
         f0_sync <= {f0_sync[0], LINK.notch_frequency_pin};
         cs_q <= cs_sync[1];
         sck_q <= sck_sync[1];
         f0_q <= f0_sync[1];
      end
   end
   wire cs_rise = cs_sync[1] & ~cs_q;
   wire cs_fall = ~cs_sync[1] & cs_q;
   wire sck_rise = sck_sync[1] & ~sck_q;
   wire sck_fall = ~sck_sync[1] & sck_q;
   wire f0_rise = f0_sync[1] & ~f0_q;

   // Sampling timebase: internal oscillator divided down, or the external notch clock
   logic [15:0] osc_cnt;
   wire osc_tick = (osc_cnt == 16'(INT_FS_DIV - 1));
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         osc_cnt <= 16'h0000;
      end else begin
         osc_cnt <= osc_tick ? 16'h0000 : osc_cnt + 16'h0001; // R9
      end
   end
   // The external pin carries the notch rate; each rising edge stands for OSR sampling ticks
   wire fs_tick = EXT_CLK_SEL_IN ? f0_rise : osc_tick; // R8
   wire [15:0] tick_weight = EXT_CLK_SEL_IN ? 16'(OSR) : 16'h0001; // R4

   // Conversion control
   csr_state_t state;
   logic [31:0] conv_cnt;
   logic [5:0] bit_cnt;
   logic [WORD_BITS-1:0] shreg;
   logic sdo;
   logic conv_start;
   logic conv_done;
   wire auto_start = ~cs_sync[1] & sck_fall & (bit_cnt == 6'(WORD_BITS - 1)); // R2 R11
   wire start = cs_rise | auto_start; // R1
   wire conv_end = (state == ST_CONV) & fs_tick & (conv_cnt + 32'(tick_weight) >= 32'(CONV_TICKS));
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         state <= ST_CONV;
         conv_cnt <= 32'h0000_0000;
         conv_start <= 1'b0;
         conv_done <= 1'b0;
      end else begin
         conv_start <= start;
         conv_done <= conv_end & ~start;
         if (start) begin
            state <= ST_CONV; // R1
            conv_cnt <= 32'h0000_0000;
         end else if (conv_end) begin
            state <= ST_READY;
         end else if (state == ST_CONV && fs_tick) begin
            conv_cnt <= conv_cnt + 32'(tick_weight);
         end
      end
   end

   // Shifter: loads on the select fall, shifts on falling clock edges at any pace
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         shreg <= 32'h0000_0000;
         bit_cnt <= 6'h00;
         sdo <= 1'b0;
      end else if (cs_fall) begin
         shreg <= {RESULT_IN[WORD_BITS-2:0], 1'b0};
         sdo <= RESULT_IN[WORD_BITS-1];
         bit_cnt <= 6'h00;
      end else if (~cs_sync[1] && sck_fall) begin
         sdo <= shreg[WORD_BITS-1]; // R5
         shreg <= {shreg[WORD_BITS-2:0], 1'b0};
         bit_cnt <= (bit_cnt == 6'(WORD_BITS - 1)) ? 6'h00 : bit_cnt + 6'h01;
      end
   end
   // Rise edge is only observed so a readout never needs a minimum clock count
   logic sck_seen;
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         sck_seen <= 1'b0;
      end else begin
         sck_seen <= cs_sync[1] ? 1'b0 : (sck_seen | sck_rise);
      end
   end

   assign LINK.sdo = sdo;
   assign LINK.sdo_oe = ~cs_sync[1]; // R12 R10
   assign CONV_START_OUT = conv_start;
   assign CONV_DONE_OUT = conv_done;
   assign FS_TICK_OUT = fs_tick;
endmodule
`default_nettype wire

/* File: rtl/csr_host.sv */
// Host end: FIFO buffer and readout sequencer driving select and serial clock
`timescale 1ns/1ps
`default_nettype none
module csr_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int unsigned AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire empty = (wr_ptr == rd_ptr);
   wire push = in_valid_in & ~full;
   wire pop = out_ready_in & ~empty;
   // Pointers carry one extra bit so full and empty are exact
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop) rd_ptr <= rd_ptr + 1'b1;
      end
   end
   always_ff @(posedge clk_in) begin
      if (push) mem[wr_ptr[AW-1:0]] <= in_data_in;
   end
   assign in_ready_out = ~full;
   assign out_valid_out = ~empty;
   assign out_data_out = mem[rd_ptr[AW-1:0]];
endmodule

module csr_host #(
   parameter int unsigned READ_BITS = csr_pkg::SHORT_BITS,
   parameter int unsigned HALF_DIV = csr_pkg::SCK_HALF_DIV
) (
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic READ_REQ_IN,
   input wire logic F0_CLK_IN,
   output logic BUSY_OUT,
   output logic WORD_VALID_OUT,
   input wire logic WORD_READY_IN,
   output logic [csr_pkg::WORD_BITS-1:0] WORD_OUT,
   csr_link_if.host LINK
);
   import csr_pkg::*;
   initial begin
      if (READ_BITS < 1 || READ_BITS > WORD_BITS || HALF_DIV < 1) $error("bad host parameters");
   end
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_LOW = 2'b01, H_HIGH = 2'b10, H_DONE = 2'b11} csr_hstate_t;
   csr_hstate_t state;
   logic [7:0] div;
   logic [5:0] nbits;
   logic [WORD_BITS-1:0] shreg;
   logic cs_n;
   logic sck;
   logic push;
   logic [1:0] sdo_sync;
   logic fifo_ready;
   wire div_end = (div == 8'(HALF_DIV - 1));
   wire last_bit = (nbits == 6'(READ_BITS - 1));
   // Hold off a readout while the buffer cannot take its word
   wire go = READ_REQ_IN & fifo_ready & ~push; // R3 R6
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         sdo_sync <= 2'h0;
      end else begin
         sdo_sync <= {sdo_sync[0], LINK.sdo};
      end
   end
   // Sequencer: clock made by a divider, stops at READ_BITS so the select keeps control
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         state <= H_IDLE;
         div <= 8'h00;
         nbits <= 6'h00;
         shreg <= 32'h0000_0000;
         cs_n <= 1'b1;
         sck <= 1'b0;
         push <= 1'b0;
      end else begin
         push <= 1'b0;
         div <= div_end ? 8'h00 : div + 8'h01;
         case (state)
            H_IDLE: begin
               div <= 8'h00;
               if (go) begin
                  cs_n <= 1'b0;
                  nbits <= 6'h00;
                  state <= H_LOW;
               end
            end
            H_LOW: begin
               if (div_end) begin
                  sck <= 1'b1;
                  state <= H_HIGH;
               end
            end
            H_HIGH: begin
               // Sample at the end of the high phase: the data path through the
               // device's synchronisers and ours is too slow to sample at the rise
               if (div_end) begin
                  sck <= 1'b0;
                  shreg <= {shreg[WORD_BITS-2:0], sdo_sync[1]}; // R11
                  if (last_bit) begin
                     state <= H_DONE; // R3
                  end else begin
                     nbits <= nbits + 6'h01;
                     state <= H_LOW;
                  end
               end
            end
            H_DONE: begin
               if (div_end) begin
                  cs_n <= 1'b1; // R1
                  push <= 1'b1;
                  state <= H_IDLE;
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end
   // Left-justify a shortened readout so bit weights stay fixed
   wire [WORD_BITS-1:0] word = shreg << (WORD_BITS - READ_BITS);
   csr_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in(CLK_IN),
      .nrst_in(NRST_IN),
      .in_valid_in(push),
      .in_ready_out(fifo_ready),
      .in_data_in(word),
      .out_valid_out(WORD_VALID_OUT),
      .out_ready_in(WORD_READY_IN),
      .out_data_out(WORD_OUT)
   );
   assign LINK.cs_n = cs_n;
   assign LINK.sck = sck; // R5
   assign LINK.notch_frequency_pin = F0_CLK_IN; // R8
   assign BUSY_OUT = (state != H_IDLE);
endmodule
`default_nettype wire

/* File: rtl/csr_link_if.sv */
// Interface joining converter end and host end of the serial link
`timescale 1ns/1ps
`default_nettype none
interface csr_link_if;
   logic cs_n;
   logic sck;
   logic sdo;
   logic sdo_oe;
   logic notch_frequency_pin;
   modport dev (input cs_n, input sck, input notch_frequency_pin, output sdo, output sdo_oe);
   modport host (output cs_n, output sck, output notch_frequency_pin, input sdo, input sdo_oe);
endinterface
`default_nettype wire

/* File: rtl/csr_pkg.sv */
// Shared constants for the conversion start and readout link
package csr_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned WORD_BITS = 32;
   localparam int unsigned SHORT_BITS = 31;
   localparam int unsigned OSR = 256;
   localparam int unsigned INT_OSC_HZ = 153_600;
   localparam int unsigned INT_OSC_PER_FS = 10;
   localparam int unsigned NOTCH_HZ = 60;
   localparam int unsigned CONV_CYCLES_PER_NOTCH = 8;
   localparam int unsigned FS_HZ = INT_OSC_HZ / INT_OSC_PER_FS;
   localparam int unsigned INT_FS_DIV = CLK_HZ / FS_HZ;
   localparam int unsigned CONV_FS_TICKS = OSR * CONV_CYCLES_PER_NOTCH;
   localparam int unsigned SCK_HALF_DIV = 4;
   localparam int unsigned FIFO_DEPTH = 16;
endpackage

/* File: sim/csr_link_props.sv */
// Checker for the serial link between host end and converter end
`timescale 1ns/1ps
`default_nettype none
module csr_link_props #(
   parameter int unsigned READ_BITS = 31
) (
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic sdo,
   input wire logic sdo_oe
);
   logic [5:0] rises;
   logic sck_d;
   // Count clock rises within one frame; cleared while deselected
   always_ff @(posedge CLK_IN) begin
      sck_d <= sck;
      rises <= (!NRST_IN || cs_n) ? 6'h00 : rises + 6'(sck && !sck_d);
   end
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!NRST_IN);
   // First clock rise comes one half period after select falls
   sequence first_edge_s;
      !sck [*4] ##1 sck;
   endsequence
   chk_oe_off_high: assert property (cs_n [*3] |-> !sdo_oe)
      else $error("data driven while deselected");
   chk_oe_on_low: assert property (!cs_n [*3] |-> sdo_oe)
      else $error("data not driven while selected");
   chk_oe_release_lag: assert property ($rose(cs_n) |-> ##[1:3] !sdo_oe)
      else $error("data line not released");
   chk_sck_idle: assert property (cs_n |-> !sck)
      else $error("clock moves while deselected");
   chk_sck_high_half: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
      else $error("clock high phase wrong");
   chk_sck_low_half: assert property ($fell(sck) |-> !sck [*4])
      else $error("clock low phase short");
   chk_first_edge: assert property ($fell(cs_n) |-> first_edge_s)
      else $error("first clock edge misplaced");
   chk_read_len: assert property ($rose(cs_n) |-> rises == READ_BITS)
      else $error("frame clock count wrong");
   chk_sdo_steady: assert property (!cs_n && sck && $past(sck) |-> $stable(sdo))
      else $error("data moved while clock high");
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Testbench joining both link ends, short and full readouts
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import csr_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, f0 = 1'b0, req1 = 1'b0, req2 = 1'b0, rdy1 = 1'b1;
   logic [31:0] res = 32'h1234_5678, w1, w2;
   logic st1, st2, dn1, tk2, v1, v2;
   logic c1d = 1'b1, c2d = 1'b1;
   int failures = 0, compares = 0, s1 = 0, e1 = 0, e2 = 0, d1 = 0, f1 = 0;
   csr_link_if lk1();
   csr_link_if lk2();
   csr_device #(.CONV_TICKS(4)) i_csr_device (.CLK_IN(clk), .NRST_IN(nrst), .EXT_CLK_SEL_IN(1'b1),
      .RESULT_IN(res), .CONV_START_OUT(st1), .CONV_DONE_OUT(dn1), .FS_TICK_OUT(), .LINK(lk1));
   csr_host i_csr_host (.CLK_IN(clk), .NRST_IN(nrst), .READ_REQ_IN(req1), .F0_CLK_IN(f0), .BUSY_OUT(),
      .WORD_VALID_OUT(v1), .WORD_READY_IN(rdy1), .WORD_OUT(w1), .LINK(lk1));
   csr_device #(.CONV_TICKS(4)) i_csr_device_2 (.CLK_IN(clk), .NRST_IN(nrst), .EXT_CLK_SEL_IN(1'b0),
      .RESULT_IN(res), .CONV_START_OUT(st2), .CONV_DONE_OUT(), .FS_TICK_OUT(tk2), .LINK(lk2));
   csr_host #(.READ_BITS(WORD_BITS)) i_csr_host_2 (.CLK_IN(clk), .NRST_IN(nrst), .READ_REQ_IN(req2),
      .F0_CLK_IN(f0), .BUSY_OUT(), .WORD_VALID_OUT(v2), .WORD_READY_IN(1'b1), .WORD_OUT(w2), .LINK(lk2));
   csr_link_props #(.READ_BITS(SHORT_BITS)) i_csr_link_props (.CLK_IN(clk), .NRST_IN(nrst),
      .cs_n(lk1.cs_n), .sck(lk1.sck), .sdo(lk1.sdo), .sdo_oe(lk1.sdo_oe));
   // System clock and a free notch clock of unrelated phase
   initial forever #5 clk = ~clk;
   initial begin
      #13;
      forever #40 f0 = ~f0;
   end
   // Tally pulses; a start seen before the frame closed counts as early
   always @(posedge clk) begin
      c1d <= lk1.cs_n;
      c2d <= lk2.cs_n;
      if (st1 === 1'b1) s1++;
      if (st1 === 1'b1 && c1d === 1'b0) e1++;
      if (st2 === 1'b1 && c2d === 1'b0) e2++;
      if (dn1 === 1'b1) d1++;
      if (lk1.cs_n === 1'b0 && c1d === 1'b1) f1++;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Short readout: word left-justified, one start after the select rise
   task automatic t_read(input logic [31:0] pat);
      int n;
      n = s1;
      res <= pat;
      req1 <= 1'b1;
      @(posedge clk);
      req1 <= 1'b0;
      for (int i = 0; i < 400 && v1 !== 1'b1; i++) @(negedge clk);
      check(w1, {pat[31:1], 1'b0});
      repeat (40) @(posedge clk);
      check(32'(s1 - n), 32'h1);
      check(32'(e1), 32'h0);
      // The conversion running out of reset ends once more than the starts
      check(32'(d1), 32'(s1 + 1));
   endtask
   // Full readout restarts on the last falling clock edge
   task automatic t_auto();
      req2 <= 1'b1;
      @(posedge clk);
      req2 <= 1'b0;
      for (int i = 0; i < 400 && v2 !== 1'b1; i++) @(negedge clk);
      check(w2, res);
      repeat (20) @(posedge clk);
      check(32'(e2), 32'h1);
   endtask
   // Held request with a stalled reader fills the buffer, then drains
   task automatic t_fill();
      int n, k;
      n = f1;
      k = 0;
      rdy1 <= 1'b0;
      req1 <= 1'b1;
      repeat (5200) @(posedge clk);
      check(32'(f1 - n), 32'(FIFO_DEPTH));
      req1 <= 1'b0;
      rdy1 <= 1'b1;
      repeat (30) begin
         @(negedge clk);
         if (v1 === 1'b1) k++;
      end
      check(32'(k), 32'(FIFO_DEPTH));
   endtask
   // Internal timebase spacing between two sampling ticks
   task automatic t_tick();
      int a;
      for (int i = 0; i < 7000 && tk2 !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      for (a = 1; a < 7000 && tk2 !== 1'b1; a++) @(negedge clk);
      check(32'(a), 32'(INT_FS_DIV));
   endtask
   task automatic summarize();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_read(32'hA5C3_0F69);
      t_read(32'hFFFF_FFFF);
      t_read(32'h8000_0001);
      t_auto();
      t_fill();
      t_tick();
      summarize();
   end
   // Whole run needs about 13k cycles; a hang is cut off well past that
   initial begin
      #500_000;
      failures++;
      summarize();
   end
endmodule
`default_nettype wire
